// ===== hdl/psm_pkg.sv
// Types shared by the port S low pin mux block
`default_nettype none
package psm_pkg;
  typedef enum logic [1:0] {
    PSM_OWN_GPIO,
    PSM_OWN_CAN,
    PSM_OWN_SERIAL,
    PSM_OWN_PWM
  } psm_owner_t;
endpackage
`default_nettype wire

// ===== hdl/psm_map.svh
// Register offsets, field positions and reset values of the port S low pin mux
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH
`define PSM_ADDR_W 4
`define PSM_OFF_DATA 4'h0
`define PSM_OFF_DIRECTION 4'h4
`define PSM_OFF_PIN_INPUT 4'h8
`define PSM_OFF_CONTROL 4'hC
`define PSM_RST_DATA 8'h00
`define PSM_RST_DIRECTION 8'h00
`define PSM_RST_CONTROL 4'h0
`define PSM_CTL_CAN_EN 0
`define PSM_CTL_SERIAL_EN 1
`define PSM_CTL_PWM_CHANNEL_SEVEN_EN 2
`define PSM_CTL_PWM_CHANNEL_SIX_EN 3
`define PSM_PIN_CAN_RX 2
`define PSM_PIN_CAN_TX 3
`define PSM_PIN_SERIAL_TX 1
`define PSM_PIN_SERIAL_RX 0
`endif

// ===== hdl/psm_pin_cell.sv
// One pin cell: registered pin drive, enable and peripheral input
`timescale 1ns/1ns
`default_nettype none
module psm_pin_cell
  import psm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Ownership and sources
  input wire psm_owner_t owner,
  input wire logic force_out,
  input wire logic force_in,
  input wire logic gpio_dir,
  input wire logic gpio_data,
  input wire logic periph_out,
  // Pin side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic periph_in
);
  logic out_next;
  logic oe_next;
  logic in_next;
  always_comb
  begin
    in_next = pin_in;
    if (owner == PSM_OWN_GPIO)
    begin
      out_next = gpio_data;
      oe_next = gpio_dir;
    end
    else
    begin
      out_next = periph_out;
      oe_next = force_out & ~force_in;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      periph_in <= 1'b0;
    end
    else
    begin
      pin_out <= out_next;
      pin_oe <= oe_next;
      periph_in <= in_next;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/psm_port_s_low.sv
// Port S lower four pins: data, direction, pin input and alternate function mux
`timescale 1ns/1ns
`default_nettype none
`include "psm_map.svh"
module psm_port_s_low
  import psm_pkg::*;
#(
  parameter int PINS = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PSM_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Peripheral sources
  input wire logic can_tx,
  input wire logic serial_tx,
  input wire logic pwm_channel_seven,
  input wire logic pwm_channel_six,
  // Peripheral sinks
  output logic can_rx,
  output logic serial_rx,
  // Pins
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe
);
  logic [PINS-1:0] port_s_data_reg;
  logic [PINS-1:0] port_s_data_next;
  logic [PINS-1:0] port_s_direction_reg;
  logic [PINS-1:0] port_s_direction_next;
  logic [3:0] control_reg;
  logic [3:0] control_next;
  logic can_rx_next;
  logic serial_rx_next;
  logic can_en;
  logic serial_en;
  logic pwm_channel_seven_en;
  logic pwm_channel_six_en;
  logic [31:0] rdata_next;
  logic ack_next;
  logic [31:0] wb_dat_next;
  psm_owner_t owner [PINS];
  logic [PINS-1:0] force_out;
  logic [PINS-1:0] force_in;
  logic [PINS-1:0] periph_out;
  logic [PINS-1:0] periph_in;
  logic wb_req;

  // Fixed priority: the higher function wins even when both are enabled
  function automatic psm_owner_t pick_owner(input logic hi_en, input psm_owner_t hi,
                                            input logic lo_en, input psm_owner_t lo);
    if (hi_en)
    begin
      pick_owner = hi;
    end
    else if (lo_en)
    begin
      pick_owner = lo;
    end
    else
    begin
      pick_owner = PSM_OWN_GPIO;
    end
  endfunction

  // Enable bits of the control register, one name per function
  assign can_en = control_reg[`PSM_CTL_CAN_EN];
  assign serial_en = control_reg[`PSM_CTL_SERIAL_EN];
  assign pwm_channel_seven_en = control_reg[`PSM_CTL_PWM_CHANNEL_SEVEN_EN];
  assign pwm_channel_six_en = control_reg[`PSM_CTL_PWM_CHANNEL_SIX_EN];

  // Ownership and forced direction per pin
  always_comb
  begin
    owner[`PSM_PIN_CAN_TX] = pick_owner(can_en, PSM_OWN_CAN,
                                        1'b0, PSM_OWN_GPIO);
    owner[`PSM_PIN_CAN_RX] = pick_owner(can_en, PSM_OWN_CAN,
                                        1'b0, PSM_OWN_GPIO);
    owner[`PSM_PIN_SERIAL_TX] = pick_owner(serial_en, PSM_OWN_SERIAL,
                                           pwm_channel_seven_en, PSM_OWN_PWM);
    owner[`PSM_PIN_SERIAL_RX] = pick_owner(serial_en, PSM_OWN_SERIAL,
                                           pwm_channel_six_en, PSM_OWN_PWM);
    force_out = '0;
    force_in = '0;
    force_out[`PSM_PIN_CAN_TX] = 1'b1;
    force_in[`PSM_PIN_CAN_RX] = 1'b1;
    force_out[`PSM_PIN_SERIAL_TX] = 1'b1;
    // Pin 0 is an input for the receiver but an output for the PWM channel
    force_in[`PSM_PIN_SERIAL_RX] = (owner[`PSM_PIN_SERIAL_RX] == PSM_OWN_SERIAL);
    force_out[`PSM_PIN_SERIAL_RX] = (owner[`PSM_PIN_SERIAL_RX] == PSM_OWN_PWM);
    periph_out = '0;
    periph_out[`PSM_PIN_CAN_TX] = can_tx;
    periph_out[`PSM_PIN_SERIAL_TX] =
      (owner[`PSM_PIN_SERIAL_TX] == PSM_OWN_SERIAL) ? serial_tx : pwm_channel_seven;
    periph_out[`PSM_PIN_SERIAL_RX] = pwm_channel_six;
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : gen_pin
      psm_pin_cell u_cell (
        .clk(clk),
        .reset_n(reset_n),
        .owner(owner[g]),
        .force_out(force_out[g]),
        .force_in(force_in[g]),
        .gpio_dir(port_s_direction_reg[g]),
        .gpio_data(port_s_data_reg[g]),
        .periph_out(periph_out[g]),
        .pin_in(pin_in[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g]),
        .periph_in(periph_in[g])
      );
    end
  endgenerate

  // Peripheral inputs see the pin only while they own it; idle level is high
  // so that a disabled receiver never sees a false start or dominant bit
  always_comb
  begin
    can_rx_next = 1'b1;
    serial_rx_next = 1'b1;
    if (can_en)
    begin
      can_rx_next = pin_in[`PSM_PIN_CAN_RX];
    end
    if (serial_en)
    begin
      serial_rx_next = pin_in[`PSM_PIN_SERIAL_RX];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      can_rx <= 1'b1;
      serial_rx <= 1'b1;
    end
    else
    begin
      can_rx <= can_rx_next;
      serial_rx <= serial_rx_next;
    end
  end

  // Register file; answers every access in the cycle after the request
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb
  begin
    port_s_data_next = port_s_data_reg;
    port_s_direction_next = port_s_direction_reg;
    control_next = control_reg;
    ack_next = wb_req;
    rdata_next = 32'h0000_0000;
    unique case (wb_adr_i)
      `PSM_OFF_DATA:
        // Mixing per bit: output pins read the latch, inputs the buffered level
        rdata_next[PINS-1:0] = (port_s_data_reg & port_s_direction_reg) |
                               (periph_in & ~port_s_direction_reg);
      `PSM_OFF_DIRECTION:
        rdata_next[PINS-1:0] = port_s_direction_reg;
      `PSM_OFF_PIN_INPUT:
        // Buffered levels are the pin cells' own input flops
        rdata_next[PINS-1:0] = periph_in;
      `PSM_OFF_CONTROL:
        rdata_next[3:0] = control_reg;
      default:
        rdata_next = 32'h0000_0000;
    endcase
    if (wb_req && wb_we_i && wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        `PSM_OFF_DATA:
          port_s_data_next = wb_dat_i[PINS-1:0];
        `PSM_OFF_DIRECTION:
          port_s_direction_next = wb_dat_i[PINS-1:0];
        `PSM_OFF_CONTROL:
          control_next = wb_dat_i[3:0];
        default:
          control_next = control_reg;
      endcase
    end
    wb_dat_next = (wb_req && !wb_we_i) ? rdata_next : 32'h0000_0000;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      port_s_data_reg <= PINS'(`PSM_RST_DATA);
      port_s_direction_reg <= PINS'(`PSM_RST_DIRECTION);
      control_reg <= `PSM_RST_CONTROL;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      port_s_data_reg <= port_s_data_next;
      port_s_direction_reg <= port_s_direction_next;
      control_reg <= control_next;
      wb_ack_o <= ack_next;
      wb_dat_o <= wb_dat_next;
    end
  end
endmodule
`default_nettype wire

// ===== verif/psm_port_s_low_chk.sv
// Checker for the port S low pin mux bus and pin ownership
`timescale 1ns/1ns
`default_nettype none
`include "psm_map.svh"
module psm_port_s_low_chk #(
  parameter int PINS = 4
)
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PSM_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Peripherals and pins
  input wire logic can_tx,
  input wire logic serial_tx,
  input wire logic pwm_channel_seven,
  input wire logic pwm_channel_six,
  input wire logic can_rx,
  input wire logic serial_rx,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe
);
  logic [3:0] ctl_reg, ctl_next, dir_reg, dir_next;
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // Shadow copies, since ownership is not visible at the ports
  always_comb
  begin
    ctl_next = ctl_reg;
    dir_next = dir_reg;
    if (wr && wb_adr_i == `PSM_OFF_CONTROL) ctl_next = wb_dat_i[3:0];
    if (wr && wb_adr_i == `PSM_OFF_DIRECTION) dir_next = wb_dat_i[3:0];
    if (!reset_n)
    begin
      ctl_next = 4'h0;
      dir_next = 4'h0;
    end
  end
  always_ff @(posedge clk)
  begin
    ctl_reg <= ctl_next;
    dir_reg <= dir_next;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  AST_ACK: assert property (s_take |=> wb_ack_o) else $error("no ack");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  AST_CAN: assert property ($past(reset_n) && $past(ctl_reg[0]) |-> pin_oe[3] && !pin_oe[2]
    && pin_out[3] == $past(can_tx) && can_rx == $past(pin_in[2])) else $error("can pins");
  AST_SERIAL: assert property ($past(reset_n) && $past(ctl_reg[1]) |-> pin_oe[1] && !pin_oe[0]
    && pin_out[1] == $past(serial_tx) && serial_rx == $past(pin_in[0])) else $error("serial");
  AST_PWM: assert property ($past(reset_n) && $past(ctl_reg[3:1]) == 3'h6 |-> pin_oe[1:0] == 2'h3
    && pin_out[1:0] == {$past(pwm_channel_seven), $past(pwm_channel_six)}) else $error("pwm");
  AST_GPIO_DIR: assert property ($past(reset_n) && $past(ctl_reg) == 4'h0
    |-> pin_oe[3:0] == $past(dir_reg)) else $error("direction");
  AST_RX_IDLE: assert property ($past(reset_n) && !$past(ctl_reg[0]) |-> can_rx) else $error("rx idle");
  AST_SERIAL_RX_IDLE: assert property ($past(reset_n) && !$past(ctl_reg[1]) |-> serial_rx)
    else $error("serial rx idle");
endmodule
`default_nettype wire

// ===== verif/psm_pin_world.sv
// Pin level model: the port drives a pin while enabled, the outside otherwise
`timescale 1ns/1ns
`default_nettype none
module psm_pin_world (
  // Port drive and outside level
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] ext,
  // Seen by the port
  output logic [3:0] pin_in
);
  // No pull resistor: an undriven pin shows only what the outside puts on it
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// ===== verif/test_port_s_low_pin_data_mux.sv
// Self-checking bench for the port S low pin mux
`timescale 1ns/1ns
`default_nettype none
`include "psm_map.svh"
module test_port_s_low_pin_data_mux;
  localparam int PINS = 4;
  logic clk = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF, ext = 4'h0, src = 4'h0, pin_in, pin_out, pin_oe;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, can_rx, serial_rx;
  wire logic can_tx = src[3], serial_tx = src[2], pwm_channel_seven = src[1];
  wire logic pwm_channel_six = src[0];
  int errors = 0, n_compared = 0;
  typedef struct {logic [3:0] ctl, dir, dat, ext, src, oe, out, rd; logic [1:0] rx;} psm_row_t;
  psm_row_t rows [8] = '{'{4'h0, 4'hF, 4'hA, 4'h0, 4'h0, 4'hF, 4'hA, 4'hA, 2'h3},
    '{4'h0, 4'h0, 4'hF, 4'h5, 4'hF, 4'h0, 4'h0, 4'h5, 2'h3},
    '{4'h0, 4'h3, 4'h6, 4'h9, 4'h0, 4'h3, 4'h2, 4'hA, 2'h3},
    '{4'h1, 4'h4, 4'h0, 4'hB, 4'h8, 4'h8, 4'h8, 4'hB, 2'h1},
    '{4'hE, 4'h1, 4'hF, 4'h2, 4'h4, 4'h2, 4'h2, 4'h3, 2'h2},
    '{4'hC, 4'h0, 4'h0, 4'h0, 4'h2, 4'h3, 4'h2, 4'h2, 2'h3},
    '{4'h8, 4'h0, 4'h0, 4'h2, 4'h1, 4'h1, 4'h1, 4'h3, 2'h3},
    '{4'h4, 4'h1, 4'h1, 4'h0, 4'h2, 4'h3, 4'h3, 4'h3, 2'h3}};
  always #50 clk = ~clk;
  psm_port_s_low #(.PINS(PINS)) DUT (.*);
  psm_pin_world u_world (.*);
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] s);
    n_compared++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      errors++;
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, 28'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (wb_ack_o !== 1'b1)
    begin
      $display("[ERR] ack expected 1 seen %b", wb_ack_o);
      errors++;
      give_verdict();
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    wb(1'b0, `PSM_OFF_CONTROL, 4'h0);
    chk("control reset", 4'h0, q[3:0]);
    chk("oe reset", 4'h0, pin_oe);
    foreach (rows[i])
    begin
      wb(1'b1, `PSM_OFF_DATA, rows[i].dat);
      wb(1'b1, `PSM_OFF_DIRECTION, rows[i].dir);
      wb(1'b1, `PSM_OFF_CONTROL, rows[i].ctl);
      {ext, src} <= {rows[i].ext, rows[i].src};
      repeat (3) @(posedge clk);
      chk("oe", rows[i].oe, pin_oe);
      chk("out", rows[i].out, pin_out & pin_oe);
      chk("rx", {2'h0, rows[i].rx}, {2'h0, can_rx, serial_rx});
      wb(1'b0, `PSM_OFF_DATA, 4'h0);
      chk("read", rows[i].rd, q[3:0]);
      $display("row %0d done", i);
    end
    wb(1'b1, `PSM_OFF_DIRECTION, 4'hF);
    wb(1'b1, `PSM_OFF_CONTROL, 4'h1);
    wb(1'b1, `PSM_OFF_DATA, 4'h5);
    repeat (2) @(posedge clk);
    chk("owned", 4'h1, pin_out & pin_oe);
    wb(1'b1, `PSM_OFF_CONTROL, 4'h0);
    repeat (2) @(posedge clk);
    chk("released", 4'h5, pin_out);
    wb(1'b1, `PSM_OFF_PIN_INPUT, 4'hA);
    wb(1'b0, `PSM_OFF_PIN_INPUT, 4'h0);
    chk("pin input", 4'h5, q[3:0]);
    wb_sel_i <= 4'hE;
    wb(1'b1, `PSM_OFF_DATA, 4'hA);
    wb_sel_i <= 4'hF;
    wb(1'b0, `PSM_OFF_DATA, 4'h0);
    chk("no lane write", 4'h5, q[3:0]);
    wb(1'b0, `PSM_OFF_DIRECTION, 4'h0);
    chk("direction", 4'hF, q[3:0]);
    wb(1'b0, 4'h2, 4'h0);
    chk("unmapped", 4'h0, q[3:0]);
    $display("owner test done");
    wb(1'b1, `PSM_OFF_CONTROL, 4'h1);
    repeat (3) @(posedge clk);
    chk("rx before reset", 4'h1, {2'h0, can_rx, serial_rx});
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("oe second reset", 4'h0, pin_oe);
    chk("rx second reset", 4'h3, {2'h0, can_rx, serial_rx});
    wb(1'b0, `PSM_OFF_DIRECTION, 4'h0);
    chk("direction second reset", 4'h0, q[3:0]);
    wb(1'b0, `PSM_OFF_CONTROL, 4'h0);
    chk("control second reset", 4'h0, q[3:0]);
    $display("reset test done");
    give_verdict();
  end
endmodule
bind psm_port_s_low psm_port_s_low_chk #(.PINS(PINS)) u_chk (.*);
`default_nettype wire
